// [design/gpio_cfg_pkg.sv]
// Shared constants for the serial-configured general-purpose pin block
package gpio_cfg_pkg;

	// Command word layout
	localparam int WORD_W       = 16;
	localparam int PIN_CNT      = 8;
	localparam int CNT_W        = 5;
	localparam int ZERO_BIT     = 15;
	localparam int SEL_HI       = 14;
	localparam int SEL_LO       = 11;
	localparam int READBACK_BIT = 10;
	localparam int BUSY_EN_BIT  = 8;
	localparam int BUSY_PIN     = 7;
	localparam int PIN_HI       = 7;

	// Register selectors
	localparam logic [3:0] SEL_OUT_CFG  = 4'h8;
	localparam logic [3:0] SEL_OUT_DATA = 4'h9;
	localparam logic [3:0] SEL_IN_CFG   = 4'ha;
	localparam logic [3:0] SEL_OD_CFG   = 4'hc;

	// Reset values and counts
	localparam logic [7:0]  PIN_RST       = 8'h00;
	localparam logic [15:0] WORD_RST      = 16'h0000;
	localparam logic [4:0]  BITS_PER_WORD = 5'h10;
	localparam logic [4:0]  LAST_BIT      = 5'h0f;
	localparam logic [4:0]  CNT_SAT       = 5'h1f;
	localparam logic [2:0]  LINK_IDLE     = 3'h6;

	// Serial clock timing made by the host divider
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS  = 60;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] HALF_LOAD = 8'(SCLK_HALF_CYC - 1);

endpackage

// [design/gpio_link_host.sv]
// Host master end: frames 16-bit commands and collects reply words
`timescale 1ns/100ps
module gpio_link_host
	import gpio_cfg_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	gpio_link_if.host_mp           link,
	input  wire logic              cmd_valid,
	input  wire logic [WORD_W-1:0] cmd_word,
	output logic                   cmd_ready,
	output logic                   rsp_valid,
	output logic      [WORD_W-1:0] rsp_word
);

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LEAD = 5'b00010,
		ST_LOW  = 5'b00100,
		ST_HIGH = 5'b01000,
		ST_GAP  = 5'b10000
	} host_state_t;

	host_state_t       state_ff;
	logic [7:0]        div_ff;
	logic [CNT_W-1:0]  bit_ff;
	logic [WORD_W-1:0] tx_ff;
	logic [WORD_W-1:0] rx_ff;
	logic              sclk_ff;
	logic              sync_n_ff;
	logic              sdo_meta_ff;
	logic              sdo_s_ff;
	logic              rsp_valid_ff;
	logic [WORD_W-1:0] rsp_word_ff;
	logic              div_done;
	logic              last_bit;

	// Force the fixed-zero bit and the output bit that busy needs
	function automatic logic [WORD_W-1:0] fix_word(
		input logic [WORD_W-1:0] w
	);
		logic [WORD_W-1:0] r;
		r           = w;
		r[ZERO_BIT] = 1'b0;
		if (w[SEL_HI:SEL_LO] == SEL_OUT_CFG && w[BUSY_EN_BIT]) begin
			r[BUSY_PIN] = 1'b1;
		end
		return r;
	endfunction

	// Reply line passes two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdo_meta_ff <= 1'b0;
			sdo_s_ff    <= 1'b0;
		end else begin
			sdo_meta_ff <= link.sdo;
			sdo_s_ff    <= sdo_meta_ff;
		end
	end

	assign div_done = (div_ff == 8'h00);
	assign last_bit = (bit_ff == LAST_BIT);

	// Frame sequencer: serial clock idles high, data set while high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff  <= ST_IDLE;
			div_ff    <= 8'h00;
			bit_ff    <= '0;
			tx_ff     <= WORD_RST;
			rx_ff     <= WORD_RST;
			sclk_ff   <= 1'b1;
			sync_n_ff <= 1'b1;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (cmd_valid) begin
						tx_ff     <= fix_word(cmd_word);
						sync_n_ff <= 1'b0;
						div_ff    <= HALF_LOAD;
						bit_ff    <= '0;
						state_ff  <= ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (div_done) begin
						sclk_ff  <= 1'b0;
						div_ff   <= HALF_LOAD;
						state_ff <= ST_LOW;
					end else begin
						div_ff <= div_ff - 8'h01;
					end
				end
				ST_LOW: begin
					if (div_done) begin
						rx_ff    <= {rx_ff[WORD_W-2:0], sdo_s_ff};
						tx_ff    <= {tx_ff[WORD_W-2:0], 1'b0};
						sclk_ff  <= 1'b1;
						div_ff   <= HALF_LOAD;
						state_ff <= ST_HIGH;
					end else begin
						div_ff <= div_ff - 8'h01;
					end
				end
				ST_HIGH: begin
					if (div_done && last_bit) begin
						sync_n_ff <= 1'b1;
						div_ff    <= HALF_LOAD;
						state_ff  <= ST_GAP;
					end else if (div_done) begin
						bit_ff   <= bit_ff + 5'h01;
						sclk_ff  <= 1'b0;
						div_ff   <= HALF_LOAD;
						state_ff <= ST_LOW;
					end else begin
						div_ff <= div_ff - 8'h01;
					end
				end
				ST_GAP: begin
					if (div_done) begin
						state_ff <= ST_IDLE;
					end else begin
						div_ff <= div_ff - 8'h01;
					end
				end
				default: begin
					state_ff  <= ST_IDLE;
					sclk_ff   <= 1'b1;
					sync_n_ff <= 1'b1;
				end
			endcase
		end
	end

	// Reply word handed out as the frame closes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_ff <= 1'b0;
			rsp_word_ff  <= WORD_RST;
		end else begin
			rsp_valid_ff <= (state_ff == ST_HIGH) && div_done && last_bit;
			if ((state_ff == ST_HIGH) && div_done && last_bit) begin
				rsp_word_ff <= rx_ff;
			end
		end
	end

	// Link and user outputs
	assign link.sclk   = sclk_ff;
	assign link.sync_n = sync_n_ff;
	assign link.sdi    = tx_ff[WORD_W-1];
	assign cmd_ready   = (state_ff == ST_IDLE);
	assign rsp_valid   = rsp_valid_ff;
	assign rsp_word    = rsp_word_ff;

endmodule

// [design/gpio_link_if.sv]
// Serial link between the host master and the pin device
`timescale 1ns/100ps
interface gpio_link_if;
	logic sclk;
	logic sync_n;
	logic sdi;
	logic sdo;

	// Host drives clock, frame and command data
	modport host_mp (
		output sclk,
		output sync_n,
		output sdi,
		input  sdo
	);

	// Device listens and returns readback data
	modport dev_mp (
		input  sclk,
		input  sync_n,
		input  sdi,
		output sdo
	);
endinterface

// [design/gpio_pin_device.sv]
// Pin device end: serial command decode and eight configurable pins
// Function
// - Word has zero MSB, 4-bit selector
// - Selector 8 makes marked pins outputs
// - Zero config bit leaves pin function alone
// - Selector 9 sets output levels
// - Data bits for non-outputs are ignored
// - Push/pull drives pin high or low
// - Selector 12 selects open-drain per pin
// - Open-drain pulls low or releases
// - Host also sets pin as output
// - Selector 10, bit 10 low: inputs
// - Bit 10 high returns inputs next frame
// - Unrequested pins read back as zero
// - Readback frame command still executes
// - Bit 8 puts busy on pin seven
// - Bits captured only inside low frame
// - Busy low converting, high when done
`timescale 1ns/100ps
module gpio_pin_device
	import gpio_cfg_pkg::*;
#(
	parameter int PIN_NUM = PIN_CNT
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	gpio_link_if.dev_mp             link,
	input  wire logic [PIN_NUM-1:0] pin_in,
	output logic      [PIN_NUM-1:0] pin_out,
	output logic      [PIN_NUM-1:0] pin_oe,
	input  wire logic               conv_busy,
	output logic      [PIN_NUM-1:0] out_mode,
	output logic      [PIN_NUM-1:0] in_mode,
	output logic      [PIN_NUM-1:0] drain_mode
);

	// The word carries exactly eight pin bits and pin seven hosts busy
	if (PIN_NUM != PIN_CNT) begin : g_bad_width
		$error("gpio_pin_device supports exactly eight pins");
	end

	// Link synchroniser, ordered {sclk, sync_n, sdi}
	logic [2:0]         link_meta_ff;
	logic [2:0]         link_s_ff;
	logic               sclk_d_ff;
	logic               sync_d_ff;
	logic               sclk_s;
	logic               sync_s;
	logic               sdi_s;
	logic               sclk_fall;
	logic               sclk_rise;
	logic               frame_start;
	logic               frame_end;
	logic               in_frame;

	// Pin input synchroniser
	logic [PIN_NUM-1:0] pin_meta_ff;
	logic [PIN_NUM-1:0] pin_s_ff;

	// Serial shifters
	logic [WORD_W-1:0]  shin_ff;
	logic [WORD_W-1:0]  shout_ff;
	logic [CNT_W-1:0]   cnt_ff;
	logic               word_done;
	logic [3:0]         sel;
	logic [PIN_NUM-1:0] pins;

	// Configuration state
	logic [PIN_NUM-1:0] out_sel_ff;
	logic [PIN_NUM-1:0] in_sel_ff;
	logic [PIN_NUM-1:0] od_sel_ff;
	logic [PIN_NUM-1:0] data_ff;
	logic               busy_en_ff;
	logic               busy_lvl_ff;
	logic               rb_pend_ff;
	logic [PIN_NUM-1:0] rb_mask_ff;

	// Pin drive
	logic [PIN_NUM-1:0] lvl;
	logic [PIN_NUM-1:0] nxt_pin_out;
	logic [PIN_NUM-1:0] nxt_pin_oe;
	logic [PIN_NUM-1:0] pin_out_ff;
	logic [PIN_NUM-1:0] pin_oe_ff;

	// Two flops on every link wire before any logic reads it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_meta_ff <= LINK_IDLE;
			link_s_ff    <= LINK_IDLE;
		end else begin
			link_meta_ff <= {link.sclk, link.sync_n, link.sdi};
			link_s_ff    <= link_meta_ff;
		end
	end

	// Previous synchronised levels for edge detection
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_ff <= 1'b1;
			sync_d_ff <= 1'b1;
		end else begin
			sclk_d_ff <= sclk_s;
			sync_d_ff <= sync_s;
		end
	end

	// Link edges and frame window
	assign sclk_s      = link_s_ff[2];
	assign sync_s      = link_s_ff[1];
	assign sdi_s       = link_s_ff[0];
	assign sclk_fall   = sclk_d_ff & ~sclk_s;
	assign sclk_rise   = ~sclk_d_ff & sclk_s;
	assign frame_start = sync_d_ff & ~sync_s;
	assign frame_end   = ~sync_d_ff & sync_s;
	assign in_frame    = ~sync_s;

	// Pins pass two flops before the readback snapshot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= PIN_RST;
			pin_s_ff    <= PIN_RST;
		end else begin
			pin_meta_ff <= pin_in;
			pin_s_ff    <= pin_meta_ff;
		end
	end

	// Command bits enter on falling serial clock inside the frame
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shin_ff <= WORD_RST;
			cnt_ff  <= '0;
		end else if (frame_start) begin
			cnt_ff <= '0;
		end else if (in_frame && sclk_fall) begin
			shin_ff <= {shin_ff[WORD_W-2:0], sdi_s};
			if (cnt_ff != CNT_SAT) begin
				cnt_ff <= cnt_ff + 5'h01; // Saturates so long frames never match
			end
		end
	end

	// Word applies at frame end only if exactly sixteen bits arrived
	assign word_done = frame_end && (cnt_ff == BITS_PER_WORD)
		&& !shin_ff[ZERO_BIT];
	assign sel  = shin_ff[SEL_HI:SEL_LO];
	assign pins = shin_ff[PIN_HI:0];

	// Pin function registers; an output or input set bit claims the pin from the other
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_sel_ff <= PIN_RST;
			in_sel_ff  <= PIN_RST;
			od_sel_ff  <= PIN_RST;
			busy_en_ff <= 1'b0;
		end else if (word_done) begin
			case (sel)
				SEL_OUT_CFG: begin
					out_sel_ff <= out_sel_ff | pins;
					busy_en_ff <= shin_ff[BUSY_EN_BIT];
					in_sel_ff  <= in_sel_ff & ~pins;
				end
				SEL_IN_CFG: begin
					if (!shin_ff[READBACK_BIT]) begin
						in_sel_ff  <= in_sel_ff | pins;
						out_sel_ff <= out_sel_ff & ~pins;
					end
				end
				SEL_OD_CFG: begin
					od_sel_ff <= pins;
				end
				default: begin
				end
			endcase
		end
	end

	// Output levels; bits for pins that are not outputs keep old value
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_ff <= PIN_RST;
		end else if (word_done && sel == SEL_OUT_DATA) begin
			data_ff <= (pins & out_sel_ff)
				| (data_ff & ~out_sel_ff);
		end
	end

	// Readback request armed by a command, consumed by the next frame
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rb_pend_ff <= 1'b0;
			rb_mask_ff <= PIN_RST;
		end else if (word_done && sel == SEL_IN_CFG
			&& shin_ff[READBACK_BIT]) begin
			rb_pend_ff <= 1'b1;
			rb_mask_ff <= pins;
		end else if (frame_start) begin
			rb_pend_ff <= 1'b0;
		end
	end

	// Reply word loaded at frame start, shifted on rising serial clock
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shout_ff <= WORD_RST;
		end else if (frame_start) begin
			if (rb_pend_ff) begin
				shout_ff <= {{(WORD_W-PIN_NUM){1'b0}},
					pin_s_ff & rb_mask_ff & in_sel_ff};
			end else begin
				shout_ff <= WORD_RST;
			end
		end else if (in_frame && sclk_rise) begin
			shout_ff <= {shout_ff[WORD_W-2:0], 1'b0};
		end
	end

	assign link.sdo = shout_ff[WORD_W-1];

	// Busy level follows the converter: low while converting
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_lvl_ff <= 1'b1;
		end else begin
			busy_lvl_ff <= ~conv_busy;
		end
	end

	// Per-pin drive: push/pull follows level, open-drain pulls low only
	for (genvar i = 0; i < PIN_NUM; i++) begin : g_pin
		if (i == BUSY_PIN) begin : g_busy
			assign lvl[i] = busy_en_ff ? busy_lvl_ff : data_ff[i];
		end else begin : g_plain
			assign lvl[i] = data_ff[i];
		end
		assign nxt_pin_oe[i]  = out_sel_ff[i]
			& (~od_sel_ff[i] | ~lvl[i]);
		assign nxt_pin_out[i] = ~od_sel_ff[i] & lvl[i];
	end

	// Registered pin drive
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out_ff <= PIN_RST;
			pin_oe_ff  <= PIN_RST;
		end else begin
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff  <= nxt_pin_oe;
		end
	end

	// Outputs straight from registers
	assign pin_out    = pin_out_ff;
	assign pin_oe     = pin_oe_ff;
	assign out_mode   = out_sel_ff;
	assign in_mode    = in_sel_ff;
	assign drain_mode = od_sel_ff;

endmodule

// [tb/configurable_pin_gpio_bench.sv]
// Self-checking bench for the serial pin block, both ends joined
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("Error at %0t got %h exp %h", $time, g, e); end end
module configurable_pin_gpio_bench;
	import gpio_cfg_pkg::*;
	logic              ref_clk, rst_n, cmd_valid, cmd_ready, rsp_valid;
	logic              conv_busy, m_busy, m_arm;
	logic [WORD_W-1:0] cmd_word, rsp_word;
	logic [7:0]        pin_out, pin_oe, out_mode, in_mode, drain_mode;
	logic [7:0]        ext, pin_in, out_b;
	logic [7:0]        m_out, m_in, m_od, m_dat, m_mask;
	logic [3:0]        sels [4] = '{SEL_OUT_CFG, SEL_OUT_DATA,
		SEL_IN_CFG, SEL_OD_CFG};
	logic [15:0]       dir_q [$] = '{16'h40ff, 16'h48a5, 16'h60f0, 16'h485a,
		16'h500f, 16'h48ff, 16'h5403, 16'h4833, 16'h4100, 16'h5080};
	int                err_total, checks, seed;
	gpio_link_if link ();
	gpio_link_if link_b ();

	// Pin wire: driven level where enabled, outside level elsewhere
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

	gpio_link_host i_gpio_link_host (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(link), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word));
	gpio_pin_device i_gpio_pin_device (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(link), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.conv_busy(conv_busy), .out_mode(out_mode), .in_mode(in_mode),
		.drain_mode(drain_mode));
	gpio_pin_device i_gpio_pin_device_b (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(link_b), .pin_in(8'h00), .pin_out(), .pin_oe(),
		.conv_busy(1'b0), .out_mode(out_b), .in_mode(), .drain_mode());
	gpio_link_sva i_gpio_link_sva (.ref_clk(ref_clk), .rst_n(rst_n),
		.sclk(link.sclk), .sync_n(link.sync_n), .sdi(link.sdi),
		.sdo(link.sdo));

	// Reference clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic clear_model();
		m_out = 8'h00;
		m_in = 8'h00;
		m_od = 8'h00;
		m_dat = 8'h00;
		m_mask = 8'h00;
		m_busy = 1'b0;
		m_arm = 1'b0;
	endtask

	// Compare registers and pin drive with the model
	task automatic chk_state();
		logic [7:0] v, oe;
		v = m_dat;
		if (m_busy && m_out[7])
			v[7] = ~conv_busy;
		oe = m_out & ~(m_od & v);
		`CHK(out_mode, m_out)
		`CHK(in_mode, m_in)
		`CHK(drain_mode, m_od)
		`CHK(pin_oe, oe)
		`CHK(pin_out & oe, v & oe)
	endtask

	// One command through the host, then model update and compare
	task automatic send(input logic [15:0] w);
		logic [7:0] p, sequence_repeat;
		int n;
		ext = 8'($random(seed));
		conv_busy = 1'($random(seed));
		repeat (4) @(posedge ref_clk) #1;
		p = w[7:0];
		if (w[14:11] == SEL_OUT_CFG && w[8])
			p[7] = 1'b1;
		sequence_repeat = m_arm ? (ext & m_mask & m_in) : 8'h00;
		n = 0;
		while (cmd_ready !== 1'b1) @(posedge ref_clk) #1;
		cmd_valid = 1'b1;
		cmd_word = w;
		@(posedge ref_clk) #1;
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(posedge ref_clk) #1;
			n++;
		end
		// A reply that never came counts against the run
		if (n >= 400)
			err_total++;
		`CHK(rsp_word, {8'h00, sequence_repeat})
		repeat (8) @(posedge ref_clk) #1;
		m_arm = 1'b0;
		if (w[14:11] == SEL_OUT_CFG) begin
			m_out = m_out | p;
			m_in = m_in & ~p;
			m_busy = w[8];
		end
		if (w[14:11] == SEL_OUT_DATA)
			m_dat = (m_dat & ~m_out) | (p & m_out);
		if (w[14:11] == SEL_IN_CFG && w[10]) begin
			m_arm = 1'b1;
			m_mask = p;
		end
		if (w[14:11] == SEL_IN_CFG && !w[10]) begin
			m_in = m_in | p;
			m_out = m_out & ~p;
		end
		if (w[14:11] == SEL_OD_CFG)
			m_od = p;
		chk_state();
	endtask

	// Bench-made frame on the second link, up to 17 bits
	task automatic raw(input logic [16:0] w, input int nb);
		link_b.sync_n = 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			link_b.sdi = w[i];
			#62.5 link_b.sclk = 1'b0;
			#62.5 link_b.sclk = 1'b1;
		end
		#62.5 link_b.sync_n = 1'b1;
		link_b.sdi = ~link_b.sdi;
		#300;
	endtask

	// Main sequence
	initial begin
		logic [15:0] w;
		seed = 70844;
		err_total = 0;
		checks = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
		conv_busy = 1'b0;
		ext = 8'h00;
		link_b.sclk = 1'b1;
		link_b.sync_n = 1'b1;
		link_b.sdi = 1'b0;
		clear_model();
		repeat (6) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		chk_state();
		raw(17'h040ff, 15);
		`CHK(out_b, 8'h00)
		raw(17'h0c001, 16);
		`CHK(out_b, 8'h00)
		raw(17'h04003, 17);
		`CHK(out_b, 8'h00)
		raw(17'h040ff, 16);
		`CHK(out_b, 8'hff)
		foreach (dir_q[i])
			send(dir_q[i]);
		repeat (50) begin
			w = {1'b0, sels[2'($random(seed))], 3'h0, 8'($random(seed))};
			if (w[14:11] == SEL_OUT_CFG)
				w[8] = 1'($random(seed));
			if (w[14:11] == SEL_IN_CFG)
				w[10] = 1'($random(seed));
			send(w);
		end
		@(posedge ref_clk) #1 rst_n = 1'b0;
		repeat (2) @(posedge ref_clk) #1;
		rst_n = 1'b1;
		clear_model();
		chk_state();
		send(16'h4001);
		complete_run();
	end

	// Watchdog against a hung handshake
	initial begin
		#400000;
		err_total++;
		complete_run();
	end
endmodule

// [tb/gpio_link_sva.sv]
// Wire-level checks on the serial link between host and device
`timescale 1ns/100ps
module gpio_link_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic sdi,
	input wire logic sdo
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [4:0] fall_cnt_ff;

	// Count serial clock falls inside the frame
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			fall_cnt_ff <= 5'h00;
		else if (sync_n)
			fall_cnt_ff <= 5'h00;
		else if ($fell(sclk))
			fall_cnt_ff <= fall_cnt_ff + 5'h01;
	end

	// Clock idles high outside frames and timing of halves
	property p_idle; sync_n |-> sclk; endproperty
	a_idle: assert property (p_idle) else $error("sclk low outside frame");
	property p_lead; $fell(sync_n) |-> sclk[*6]; endproperty
	a_lead: assert property (p_lead) else $error("lead too short");
	property p_low; $fell(sclk) |-> !sclk[*5] ##[1:2] sclk; endproperty
	a_low: assert property (p_low) else $error("low half wrong");
	property p_high; $rose(sclk) && !sync_n |-> sclk[*5]; endproperty
	a_high: assert property (p_high) else $error("high half short");
	property p_sdi; $fell(sclk) |-> $stable(sdi); endproperty
	a_sdi: assert property (p_sdi) else $error("sdi moved at fall");
	// Word content and framing
	property p_msb; $fell(sclk) && fall_cnt_ff == 5'h00 |-> !sdi; endproperty
	a_msb: assert property (p_msb) else $error("first bit not zero");
	property p_count; $rose(sync_n) |-> fall_cnt_ff == 5'h10; endproperty
	a_count: assert property (p_count) else $error("frame not 16 bits");
	property p_gap; $rose(sync_n) |-> sync_n[*6]; endproperty
	a_gap: assert property (p_gap) else $error("frame gap short");
	property p_upper; $fell(sclk) && fall_cnt_ff < 5'h08 |-> !sdo; endproperty
	a_upper: assert property (p_upper) else $error("reply upper bit set");
	c_frame: cover property ($rose(sync_n));
	c_reply: cover property ($fell(sclk) && sdo);
	c_lead: cover property ($fell(sync_n));
endmodule
